// >>> hdl/oded_pkg.sv
package oded_pkg;

    // CPU bus and channel geometry
    localparam int ADDR_W   = 20;
    localparam int DATA_W   = 16;
    localparam int PC_CH    = 8;
    localparam int PC_IDX_W = 3;
    localparam int REG_AW   = 8;
    localparam int STAT_W   = 11;

    // Register byte offsets
    localparam logic [REG_AW-1:0] OFF_CTRL    = 8'h00;
    localparam logic [REG_AW-1:0] OFF_PC_EN   = 8'h04;
    localparam logic [REG_AW-1:0] OFF_STATUS  = 8'h08;
    localparam logic [REG_AW-1:0] OFF_MASK    = 8'h0C;
    localparam logic [REG_AW-1:0] OFF_PC_BASE = 8'h10;
    localparam logic [REG_AW-1:0] OFF_PC_END  = 8'h30;
    localparam logic [REG_AW-1:0] OFF_A_ADDR  = 8'h30;
    localparam logic [REG_AW-1:0] OFF_A_CFG   = 8'h34;
    localparam logic [REG_AW-1:0] OFF_A_DATA  = 8'h38;
    localparam logic [REG_AW-1:0] OFF_B_ADDR  = 8'h3C;
    localparam logic [REG_AW-1:0] OFF_B_CFG   = 8'h40;

    // Field positions
    localparam int CTRL_MODE_W    = 3;
    localparam int CFG_AMN_LSB    = 0;
    localparam int AMN_W          = 4;
    localparam int CFG_AME        = 4;
    localparam int CFG_DIR_LSB    = 5;
    localparam int CFG_SZ_LSB     = 7;
    localparam int CFG_CMP        = 9;
    localparam int CFG_DME        = 10;
    localparam int DATA_MASK_LSB  = 16;
    localparam int ST_A_BIT       = 8;
    localparam int ST_B_BIT       = 9;
    localparam int ST_BRK_BIT     = 10;

    // Data lanes compared per access size
    localparam logic [DATA_W-1:0] BYTE_LANES = 16'h00FF;
    localparam logic [DATA_W-1:0] WORD_LANES = 16'hFFFF;

    typedef enum logic [2:0] {BRK_NONE, BRK_A, BRK_A_OR_B, BRK_A_AND_B, BRK_B_THEN_A} oded_brk_t;
    typedef enum logic [1:0] {DIR_RW, DIR_READ, DIR_WRITE} oded_dir_t;
    typedef enum logic [1:0] {SZ_ANY, SZ_BYTE, SZ_WORD} oded_size_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              amask_en;
        logic [AMN_W-1:0]  amask_n;
        oded_dir_t         dir;
        oded_size_t        size;
        logic              cmp_en;
        logic              dmask_en;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] dmask;
    } oded_dacfg_t;

endpackage

// >>> hdl/oded_cmp_if.sv
`timescale 1ns/1ps
interface oded_cmp_if;
    import oded_pkg::*;

    oded_dacfg_t       cfg;
    logic              acc_valid;
    logic              acc_write;
    logic              acc_word;
    logic [ADDR_W-1:0] acc_addr;
    logic [DATA_W-1:0] acc_data;
    logic              hit;

    modport cmp  (input cfg, acc_valid, acc_write, acc_word, acc_addr, acc_data, output hit);
    modport user (output cfg, acc_valid, acc_write, acc_word, acc_addr, acc_data, input hit);
endinterface

// >>> hdl/oded_cmp.sv
`timescale 1ns/1ps
module oded_cmp #(
    parameter bit HAS_DATA = 1'b1
) (
    // Access and configuration
    oded_cmp_if.cmp bus
);
    import oded_pkg::*;

    logic [ADDR_W-1:0] amask;
    logic [DATA_W-1:0] dlanes;
    logic              addr_ok;
    logic              dir_ok;
    logic              size_ok;
    logic              data_ok;

    always_comb
    begin
        amask = {ADDR_W{1'b1}};
        if (bus.cfg.amask_en)
        begin
            amask = {ADDR_W{1'b1}} << bus.cfg.amask_n;
        end
        addr_ok = ((bus.acc_addr ^ bus.cfg.addr) & amask) == '0;
        case (bus.cfg.dir)
            DIR_RW:    dir_ok = 1'b1;
            DIR_READ:  dir_ok = !bus.acc_write;
            DIR_WRITE: dir_ok = bus.acc_write;
            default:   dir_ok = 1'b0;
        endcase
        case (bus.cfg.size)
            SZ_ANY:  size_ok = 1'b1;
            SZ_BYTE: size_ok = !bus.acc_word;
            SZ_WORD: size_ok = bus.acc_word;
            default: size_ok = 1'b0;
        endcase
        // Byte accesses carry data in the low lane only
        dlanes = bus.acc_word ? WORD_LANES : BYTE_LANES;
        if (bus.cfg.dmask_en)
        begin
            dlanes = dlanes & ~bus.cfg.dmask;
        end
        data_ok = !HAS_DATA || !bus.cfg.cmp_en
                  || (((bus.acc_data ^ bus.cfg.data) & dlanes) == '0);
        bus.hit = bus.acc_valid && addr_ok && dir_ok && size_ok && data_ok;
    end

endmodule // oded_cmp

// >>> hdl/oded_top.sv
// Contract
// - Eight program-address channels, index 0 to 7, each with its own enable bit.
// - An enabled channel equal to the address of the next instruction requests a break.
// - The data comparator checks each data access address against a target address.
// - With address masking on, the low 0 to 15 address bits are ignored; off after reset.
// - Matches are qualified by direction: read only, write only, or either.
// - Matches are qualified by size, byte, word or any; a differing size gives no event.
// - With data compare on, data must equal an 8-bit value for bytes, 16-bit for words.
// - Data compare is off after reset, so events then depend on address, direction, size.
// - With data masking on, masked bits are not compared; an all-zero mask compares all.
// - Break on event A alone, on A or B, on both A and B, or on B followed by A.
// - Only event A has data qualifiers; event B uses address, direction and size alone.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module oded_top (
    // Clock and reset
    input  logic                                       CORE_CLK,
    input  logic                                       SYS_RST,
    // Instruction about to execute
    input  logic                                       IFETCH_VALID,
    input  logic [oded_pkg::ADDR_W-1:0]                IFETCH_ADDR,
    // CPU data access
    input  logic                                       DACC_VALID,
    input  logic                                       DACC_WRITE,
    input  logic                                       DACC_WORD,
    input  logic [oded_pkg::ADDR_W-1:0]                DACC_ADDR,
    input  logic [oded_pkg::DATA_W-1:0]                DACC_DATA,
    // Avalon-MM slave
    input  logic [oded_pkg::REG_AW-1:0]                AVS_ADDRESS,
    input  logic                                       AVS_READ,
    input  logic                                       AVS_WRITE,
    input  logic [31:0]                                AVS_WRITEDATA,
    input  logic [3:0]                                 AVS_BYTEENABLE,
    output logic [31:0]                                AVS_READDATA,
    output logic                                       AVS_WAITREQUEST,
    // Matches, break and interrupt
    output logic [oded_pkg::PC_CH-1:0]                 PC_MATCH,
    output logic                                       DA_A_EVENT,
    output logic                                       DA_B_EVENT,
    output logic                                       BREAK_REQ,
    output logic                                       IRQ
);
    import oded_pkg::*;

    typedef struct packed {
        oded_brk_t                      brk_mode;
        logic [PC_CH-1:0]               pc_en;
        logic [PC_CH-1:0][ADDR_W-1:0]   pc_addr;
        oded_dacfg_t                    a;
        oded_dacfg_t                    b;
        logic [STAT_W-1:0]              status;
        logic [STAT_W-1:0]              mask;
        logic                           ack;
        logic [31:0]                    rdata;
        logic [PC_CH-1:0]               pc_pulse;
        logic                           a_pulse;
        logic                           b_pulse;
        logic                           brk_pulse;
        logic                           seen_a;
        logic                           seen_b;
    } oded_state_t;

    localparam oded_state_t ST_RST = '0;

    oded_state_t        st_ff;
    oded_state_t        nxt_st;
    logic [PC_CH-1:0]   pc_hit;
    logic               req;
    logic [31:0]        cur_word;
    logic [31:0]        wword;
    logic [STAT_W-1:0]  clr;
    logic [STAT_W-1:0]  ev;
    logic               ctrl_wr;
    logic               brk_da;
    logic [PC_IDX_W:0]  slot;

    oded_cmp_if a_if ();
    oded_cmp_if b_if ();

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Valid flag on top, channel index below
    function automatic logic [PC_IDX_W:0] pc_slot(input logic [REG_AW-1:0] a);
        logic [REG_AW-1:0] d;
        d = a - OFF_PC_BASE;
        return {(a >= OFF_PC_BASE) && (a < OFF_PC_END) && (a[1:0] == 2'h0),
                d[PC_IDX_W+1:2]};
    endfunction

    function automatic logic [31:0] cfg_word(input oded_dacfg_t c);
        logic [31:0] w;
        w = '0;
        w[CFG_AMN_LSB +: AMN_W] = c.amask_n;
        w[CFG_AME]              = c.amask_en;
        w[CFG_DIR_LSB +: 2]     = c.dir;
        w[CFG_SZ_LSB +: 2]      = c.size;
        w[CFG_CMP]              = c.cmp_en;
        w[CFG_DME]              = c.dmask_en;
        return w;
    endfunction

    function automatic oded_dacfg_t cfg_load(input oded_dacfg_t c, input logic [31:0] w);
        oded_dacfg_t r;
        r          = c;
        r.amask_n  = w[CFG_AMN_LSB +: AMN_W];
        r.amask_en = w[CFG_AME];
        r.dir      = oded_dir_t'(w[CFG_DIR_LSB +: 2]);
        r.size     = oded_size_t'(w[CFG_SZ_LSB +: 2]);
        r.cmp_en   = w[CFG_CMP];
        r.dmask_en = w[CFG_DME];
        return r;
    endfunction

    // Shared by readback and by the byte-enable merge on writes
    function automatic logic [31:0] read_word(input oded_state_t s,
                                              input logic [REG_AW-1:0] a);
        logic [PC_IDX_W:0] ps;
        ps = pc_slot(a);
        case (a)
            OFF_CTRL:   read_word = 32'(s.brk_mode);
            OFF_PC_EN:  read_word = 32'(s.pc_en);
            OFF_STATUS: read_word = 32'(s.status);
            OFF_MASK:   read_word = 32'(s.mask);
            OFF_A_ADDR: read_word = 32'(s.a.addr);
            OFF_A_CFG:  read_word = cfg_word(s.a);
            OFF_A_DATA: read_word = {s.a.dmask, s.a.data};
            OFF_B_ADDR: read_word = 32'(s.b.addr);
            OFF_B_CFG:  read_word = cfg_word(s.b);
            default:
            begin
                read_word = ps[PC_IDX_W] ? 32'(s.pc_addr[ps[PC_IDX_W-1:0]]) : 32'h0000_0000;
            end
        endcase
    endfunction

    // One comparator per channel, all in parallel with the fetch
    genvar gi;
    generate
        for (gi = 0; gi < PC_CH; gi++)
        begin : g_pc
            assign pc_hit[gi] = IFETCH_VALID && st_ff.pc_en[gi]
                                && (IFETCH_ADDR == st_ff.pc_addr[gi]);
        end
    endgenerate

    assign a_if.cfg       = st_ff.a;
    assign a_if.acc_valid = DACC_VALID;
    assign a_if.acc_write = DACC_WRITE;
    assign a_if.acc_word  = DACC_WORD;
    assign a_if.acc_addr  = DACC_ADDR;
    assign a_if.acc_data  = DACC_DATA;
    assign b_if.cfg       = st_ff.b;
    assign b_if.acc_valid = DACC_VALID;
    assign b_if.acc_write = DACC_WRITE;
    assign b_if.acc_word  = DACC_WORD;
    assign b_if.acc_addr  = DACC_ADDR;
    assign b_if.acc_data  = DACC_DATA;

    oded_cmp #(.HAS_DATA(1'b1)) u_cmp_a (.bus(a_if));
    oded_cmp #(.HAS_DATA(1'b0)) u_cmp_b (.bus(b_if));

    always_comb
    begin
        nxt_st   = st_ff;
        req      = AVS_READ || AVS_WRITE;
        cur_word = read_word(st_ff, AVS_ADDRESS);
        wword    = (cur_word & ~lane_mask(AVS_BYTEENABLE))
                   | (AVS_WRITEDATA & lane_mask(AVS_BYTEENABLE));
        slot     = pc_slot(AVS_ADDRESS);
        clr      = '0;
        ctrl_wr  = 1'b0;
        brk_da   = 1'b0;

        // Every access waits exactly one cycle; read data is latched in that cycle
        nxt_st.ack = req && !st_ff.ack;
        if (req && !st_ff.ack)
        begin
            nxt_st.rdata = cur_word;
        end
        // Only the bits that were returned are cleared, so a late event survives
        if (AVS_READ && st_ff.ack && (AVS_ADDRESS == OFF_STATUS))
        begin
            clr = st_ff.rdata[STAT_W-1:0];
        end

        if (AVS_WRITE && st_ff.ack)
        begin
            case (AVS_ADDRESS)
                OFF_CTRL:
                begin
                    nxt_st.brk_mode = oded_brk_t'(wword[CTRL_MODE_W-1:0]);
                    ctrl_wr         = 1'b1;
                end
                OFF_PC_EN:  nxt_st.pc_en  = wword[PC_CH-1:0];
                OFF_MASK:   nxt_st.mask   = wword[STAT_W-1:0];
                OFF_A_ADDR: nxt_st.a.addr = wword[ADDR_W-1:0];
                OFF_A_CFG:  nxt_st.a      = cfg_load(st_ff.a, wword);
                OFF_A_DATA:
                begin
                    nxt_st.a.data  = wword[DATA_W-1:0];
                    nxt_st.a.dmask = wword[DATA_MASK_LSB +: DATA_W];
                end
                OFF_B_ADDR: nxt_st.b.addr = wword[ADDR_W-1:0];
                OFF_B_CFG:
                begin
                    nxt_st.b          = cfg_load(st_ff.b, wword);
                    nxt_st.b.cmp_en   = 1'b0;
                    nxt_st.b.dmask_en = 1'b0;
                end
                default:
                begin
                    if (slot[PC_IDX_W])
                    begin
                        nxt_st.pc_addr[slot[PC_IDX_W-1:0]] = wword[ADDR_W-1:0];
                    end
                end
            endcase
        end

        // Same-cycle B does not count as coming before A
        case (st_ff.brk_mode)
            BRK_NONE:     brk_da = 1'b0;
            BRK_A:        brk_da = a_if.hit;
            BRK_A_OR_B:   brk_da = a_if.hit || b_if.hit;
            BRK_A_AND_B:  brk_da = (a_if.hit || st_ff.seen_a) && (b_if.hit || st_ff.seen_b);
            BRK_B_THEN_A: brk_da = a_if.hit && st_ff.seen_b;
            default:      brk_da = 1'b0;
        endcase
        if (brk_da)
        begin
            nxt_st.seen_a = 1'b0;
            nxt_st.seen_b = 1'b0;
        end
        else
        begin
            // A CTRL write drops old history, but an event in the same cycle is kept
            nxt_st.seen_a = (st_ff.seen_a && !ctrl_wr) || a_if.hit;
            nxt_st.seen_b = (st_ff.seen_b && !ctrl_wr) || b_if.hit;
        end

        nxt_st.pc_pulse  = pc_hit;
        nxt_st.a_pulse   = a_if.hit;
        nxt_st.b_pulse   = b_if.hit;
        nxt_st.brk_pulse = brk_da || (|pc_hit);

        ev                = '0;
        ev[PC_CH-1:0]     = pc_hit;
        ev[ST_A_BIT]      = a_if.hit;
        ev[ST_B_BIT]      = b_if.hit;
        ev[ST_BRK_BIT]    = nxt_st.brk_pulse;
        // Set wins over a clear in the same cycle
        nxt_st.status     = (st_ff.status & ~clr) | ev;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign AVS_READDATA    = st_ff.rdata;
    assign AVS_WAITREQUEST = req && !st_ff.ack;
    assign PC_MATCH        = st_ff.pc_pulse;
    assign DA_A_EVENT      = st_ff.a_pulse;
    assign DA_B_EVENT      = st_ff.b_pulse;
    assign BREAK_REQ       = st_ff.brk_pulse;
    assign IRQ             = |(st_ff.status & st_ff.mask);

    // Helper for the masked-address check
    logic [AMN_W-1:0] chk_sh;
    assign chk_sh = st_ff.a.amask_en ? st_ff.a.amask_n : '0;

    AST_PC_BREAK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (|pc_hit) |=> (BREAK_REQ && (PC_MATCH == $past(pc_hit))))
        else $error("PC hit did not raise a break");

    AST_PC_DISABLED: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ##1 ((PC_MATCH & ~$past(st_ff.pc_en)) == '0))
        else $error("disabled channel matched");

    AST_A_ADDR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (DACC_VALID && !st_ff.a.amask_en && (DACC_ADDR != st_ff.a.addr)) |=> !DA_A_EVENT)
        else $error("event A on wrong address");

    AST_A_AMASK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        DA_A_EVENT |-> $past((DACC_ADDR >> chk_sh) == (st_ff.a.addr >> chk_sh)))
        else $error("event A outside masked range");

    AST_A_DIR: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        DA_A_EVENT |-> $past((st_ff.a.dir != DIR_READ || !DACC_WRITE)
                             && (st_ff.a.dir != DIR_WRITE || DACC_WRITE)))
        else $error("event A with wrong direction");

    AST_A_SIZE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        DA_A_EVENT |-> $past(st_ff.a.size == SZ_ANY
                             || ((st_ff.a.size == SZ_WORD) == DACC_WORD)))
        else $error("event A with wrong size");

    AST_A_DATA: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        DA_A_EVENT |-> $past(!st_ff.a.cmp_en || st_ff.a.dmask_en
                             || (DACC_DATA[7:0] == st_ff.a.data[7:0])))
        else $error("event A with unequal data");

    AST_A_DMASK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        DA_A_EVENT |-> $past(!st_ff.a.cmp_en || !st_ff.a.dmask_en
            || ((((DACC_DATA ^ st_ff.a.data) & ~st_ff.a.dmask) & BYTE_LANES) == '0)))
        else $error("event A with unequal unmasked data");

    AST_PULSE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !DACC_VALID |=> (!DA_A_EVENT && !DA_B_EVENT))
        else $error("data event without an access");

    AST_BRK_A: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (st_ff.brk_mode == BRK_A && a_if.hit) |=> BREAK_REQ)
        else $error("event A break missing");

    AST_BRK_ORDER: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (st_ff.brk_mode == BRK_B_THEN_A && !st_ff.seen_b && !(|pc_hit)) |=> !BREAK_REQ)
        else $error("break before B was seen");

    AST_RST_CFG: assert property (@(posedge CORE_CLK)
        ($past(SYS_RST) && !SYS_RST)
        |-> (!st_ff.a.cmp_en && !st_ff.a.amask_en && (st_ff.pc_en == '0)))
        else $error("compare or masking on after reset");

    AST_BUS_ACK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        AVS_WAITREQUEST |=> (st_ff.ack && !AVS_WAITREQUEST))
        else $error("waitrequest held beyond one cycle");

endmodule // oded_top

// >>> dv/oded_cpu_model.sv
`timescale 1ns/1ps
module oded_cpu_model (
    // Clock
    input  logic                        clk,
    // Instruction about to execute
    output logic                        fetch_valid,
    output logic [oded_pkg::ADDR_W-1:0] fetch_addr,
    // Data access
    output logic                        acc_valid,
    output logic                        acc_write,
    output logic                        acc_word,
    output logic [oded_pkg::ADDR_W-1:0] acc_addr,
    output logic [oded_pkg::DATA_W-1:0] acc_data
);
    import oded_pkg::*;

    initial
    begin
        fetch_valid = 1'h0;
        fetch_addr  = 20'hFFFFF;
        acc_valid   = 1'h0;
        acc_write   = 1'h0;
        acc_word    = 1'h0;
        acc_addr    = 20'hFFFFF;
        acc_data    = 16'hFFFF;
    end

    // Idle lines show the inverse of the last value so a stale copy never matches
    task automatic fetch(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        fetch_valid <= 1'h1;
        fetch_addr  <= a;
        @(posedge clk);
        fetch_valid <= 1'h0;
        fetch_addr  <= ~a;
    endtask

    task automatic access(input logic w, input logic wd, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk);
        acc_valid <= 1'h1;
        acc_write <= w;
        acc_word  <= wd;
        acc_addr  <= a;
        acc_data  <= d;
        @(posedge clk);
        acc_valid <= 1'h0;
        acc_write <= ~w;
        acc_word  <= ~wd;
        acc_addr  <= ~a;
        acc_data  <= ~d;
    endtask
endmodule // oded_cpu_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    import oded_pkg::*;

    typedef struct packed {
        logic [10:0]       cfg;
        logic [31:0]       adata;
        logic              wr;
        logic              wd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              exp;
    } oded_row_t;

    logic              CORE_CLK = 1'h0;
    logic              SYS_RST  = 1'h1;
    logic              IFETCH_VALID, DACC_VALID, DACC_WRITE, DACC_WORD;
    logic [ADDR_W-1:0] IFETCH_ADDR, DACC_ADDR;
    logic [DATA_W-1:0] DACC_DATA;
    logic [REG_AW-1:0] AVS_ADDRESS   = 8'h00;
    logic              AVS_READ      = 1'h0;
    logic              AVS_WRITE     = 1'h0;
    logic [31:0]       AVS_WRITEDATA = 32'h0;
    logic [31:0]       AVS_READDATA, rd;
    logic              AVS_WAITREQUEST, DA_A_EVENT, DA_B_EVENT, BREAK_REQ, IRQ;
    logic [PC_CH-1:0]  PC_MATCH;
    int                fails  = 0;
    int                checks = 0;

    // A target 400h, B target 400h exact; cfg bits: count, mask en, dir, size, cmp, dmask
    oded_row_t rows [22] = '{
        '{11'h000, 32'h0, 1'h0, 1'h0, 20'h00400, 16'h0000, 1'h1},
        '{11'h000, 32'h0, 1'h0, 1'h0, 20'h00401, 16'h0000, 1'h0},
        '{11'h014, 32'h0, 1'h0, 1'h0, 20'h0040F, 16'h0000, 1'h1},
        '{11'h014, 32'h0, 1'h0, 1'h0, 20'h00410, 16'h0000, 1'h0},
        '{11'h011, 32'h0, 1'h0, 1'h0, 20'h00401, 16'h0000, 1'h1},
        '{11'h01F, 32'h0, 1'h0, 1'h0, 20'h07ABC, 16'h0000, 1'h1},
        '{11'h01F, 32'h0, 1'h0, 1'h0, 20'h08400, 16'h0000, 1'h0},
        '{11'h020, 32'h0, 1'h1, 1'h0, 20'h00400, 16'h0000, 1'h0},
        '{11'h020, 32'h0, 1'h0, 1'h0, 20'h00400, 16'h0000, 1'h1},
        '{11'h040, 32'h0, 1'h1, 1'h0, 20'h00400, 16'h0000, 1'h1},
        '{11'h040, 32'h0, 1'h0, 1'h0, 20'h00400, 16'h0000, 1'h0},
        '{11'h080, 32'h0, 1'h0, 1'h1, 20'h00400, 16'h0000, 1'h0},
        '{11'h080, 32'h0, 1'h0, 1'h0, 20'h00400, 16'h0000, 1'h1},
        '{11'h100, 32'h0, 1'h0, 1'h1, 20'h00400, 16'h0000, 1'h1},
        '{11'h100, 32'h0, 1'h0, 1'h0, 20'h00400, 16'h0000, 1'h0},
        '{11'h200, 32'h12, 1'h0, 1'h0, 20'h00400, 16'hFF12, 1'h1},
        '{11'h200, 32'h12, 1'h0, 1'h0, 20'h00400, 16'h0013, 1'h0},
        '{11'h300, 32'h1234, 1'h1, 1'h1, 20'h00400, 16'h1234, 1'h1},
        '{11'h300, 32'h1234, 1'h1, 1'h1, 20'h00400, 16'h1235, 1'h0},
        '{11'h600, 32'h000F1230, 1'h1, 1'h1, 20'h00400, 16'h123F, 1'h1},
        '{11'h600, 32'h000F1230, 1'h1, 1'h1, 20'h00400, 16'h133F, 1'h0},
        '{11'h600, 32'h00001230, 1'h1, 1'h1, 20'h00400, 16'h1231, 1'h0}
    };

    oded_top oded_top_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .IFETCH_VALID(IFETCH_VALID),
        .IFETCH_ADDR(IFETCH_ADDR), .DACC_VALID(DACC_VALID), .DACC_WRITE(DACC_WRITE),
        .DACC_WORD(DACC_WORD), .DACC_ADDR(DACC_ADDR), .DACC_DATA(DACC_DATA),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .PC_MATCH(PC_MATCH), .DA_A_EVENT(DA_A_EVENT),
        .DA_B_EVENT(DA_B_EVENT), .BREAK_REQ(BREAK_REQ), .IRQ(IRQ));

    oded_cpu_model oded_cpu_model_i (.clk(CORE_CLK), .fetch_valid(IFETCH_VALID),
        .fetch_addr(IFETCH_ADDR), .acc_valid(DACC_VALID), .acc_write(DACC_WRITE),
        .acc_word(DACC_WORD), .acc_addr(DACC_ADDR), .acc_data(DACC_DATA));

    always #50 CORE_CLK = ~CORE_CLK;

    task automatic end_sim();
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_bit(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_vec(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Holds the request until waitrequest is sampled low; read data taken at that edge
    task automatic avs(input logic wr, input logic [REG_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge CORE_CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= wr;
        AVS_READ      <= ~wr;
        n = 0;
        do
        begin
            @(posedge CORE_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'h0 && n < 20);
        q = AVS_READDATA;
        AVS_WRITE <= 1'h0;
        AVS_READ  <= 1'h0;
        if (n >= 20)
        begin
            fails++;
            end_sim();
        end
    endtask

    task automatic step(input logic [ADDR_W-1:0] a, input logic e);
        oded_cpu_model_i.access(1'h0, 1'h0, a, 16'h0000);
        @(negedge CORE_CLK);
        chk_bit(BREAK_REQ, e);
    endtask

    initial
    begin
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        avs(1'h1, OFF_A_ADDR, 32'h400, rd);
        avs(1'h1, OFF_B_ADDR, 32'h400, rd);
        avs(1'h1, OFF_B_CFG, 32'h600, rd);
        avs(1'h0, OFF_B_CFG, 32'h0, rd);
        chk_vec(rd, 32'h0);
        avs(1'h1, OFF_CTRL, 32'h1, rd);
        foreach (rows[i])
        begin
            avs(1'h1, OFF_A_CFG, 32'(rows[i].cfg), rd);
            avs(1'h1, OFF_A_DATA, rows[i].adata, rd);
            oded_cpu_model_i.access(rows[i].wr, rows[i].wd, rows[i].addr, rows[i].data);
            @(negedge CORE_CLK);
            chk_bit(DA_A_EVENT, rows[i].exp);
            chk_bit(DA_B_EVENT, rows[i].addr == 20'h00400);
            chk_bit(BREAK_REQ, rows[i].exp);
            @(negedge CORE_CLK);
            chk_bit(DA_A_EVENT, 1'h0);
        end
        // Channel 5 left disarmed to prove the per-channel enable
        avs(1'h1, OFF_CTRL, 32'h0, rd);
        for (int i = 0; i < PC_CH; i++)
            avs(1'h1, OFF_PC_BASE + 8'(4 * i), 32'h1000 + 32'(i), rd);
        avs(1'h1, OFF_PC_EN, 32'hDF, rd);
        for (int i = 0; i < PC_CH; i++)
        begin
            oded_cpu_model_i.fetch(20'h01000 + 20'(i));
            @(negedge CORE_CLK);
            chk_vec(32'(PC_MATCH), (i == 5) ? 32'h0 : 32'h1 << i);
            chk_bit(BREAK_REQ, i != 5);
            @(negedge CORE_CLK);
            chk_vec(32'(PC_MATCH), 32'h0);
        end
        avs(1'h1, OFF_A_CFG, 32'h0, rd);
        avs(1'h1, OFF_B_ADDR, 32'h500, rd);
        avs(1'h1, OFF_B_CFG, 32'h0, rd);
        step(20'h00400, 1'h0);
        avs(1'h1, OFF_CTRL, 32'h2, rd);
        step(20'h00500, 1'h1);
        avs(1'h1, OFF_CTRL, 32'h3, rd);
        step(20'h00500, 1'h0);
        step(20'h00400, 1'h1);
        avs(1'h1, OFF_CTRL, 32'h4, rd);
        step(20'h00400, 1'h0);
        step(20'h00500, 1'h0);
        step(20'h00400, 1'h1);
        // Status and interrupt
        avs(1'h0, OFF_STATUS, 32'h0, rd);
        avs(1'h1, OFF_MASK, 32'h100, rd);
        avs(1'h1, OFF_CTRL, 32'h1, rd);
        step(20'h00400, 1'h1);
        chk_bit(IRQ, 1'h1);
        avs(1'h0, OFF_STATUS, 32'h0, rd);
        chk_vec(rd, 32'h500);
        @(negedge CORE_CLK);
        chk_bit(IRQ, 1'h0);
        avs(1'h1, OFF_MASK, 32'h200, rd);
        step(20'h00400, 1'h1);
        chk_bit(IRQ, 1'h0);
        avs(1'h1, OFF_STATUS, 32'hFFFFFFFF, rd);
        avs(1'h0, OFF_STATUS, 32'h0, rd);
        chk_vec(rd, 32'h500);
        avs(1'h1, 8'hFC, 32'hFFFFFFFF, rd);
        avs(1'h0, 8'hFC, 32'h0, rd);
        chk_vec(rd, 32'h0);
        // Second reset in mid-run brings every setting back to its default
        @(posedge CORE_CLK);
        SYS_RST <= 1'h1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        avs(1'h0, OFF_A_CFG, 32'h0, rd);
        chk_vec(rd, 32'h0);
        avs(1'h0, OFF_PC_EN, 32'h0, rd);
        chk_vec(rd, 32'h0);
        oded_cpu_model_i.access(1'h1, 1'h1, 20'h00000, 16'hABCD);
        @(negedge CORE_CLK);
        chk_bit(DA_A_EVENT, 1'h1);
        chk_bit(BREAK_REQ, 1'h0);
        end_sim();
    end
endmodule // tb
